// >>> design/aiec_ctrl.sv
`timescale 1ns/1ps
// Operation
// - codes 0x00..0x13 route analog pin N to the positive input
// - codes 0x18..0x1C select temp, bandgap, quarter supplies, DAC; others reserved
// - window event output enabled emits event on every window match
// - result event output enabled emits event on every available result
// - flush input enabled: incoming event flushes pipeline and starts conversion
// - start input enabled: incoming event starts a new conversion
// - enable-clear write of one clears enable and withdraws request; zero ignored
// - enable-set write of one sets enable; zero ignored
// - enables share layout sync/window/overrun/result at bits 3..0, read back
// - overrun flag with enable raises interrupt request
// - window match flag with enable raises interrupt request
// - result available flag with enable raises interrupt request
// - sync done flag with enable raises interrupt request
// - overrun flag sets when result stored before previous one read
// - result flag sets on new result; cleared by write one or result read
module aiec_ctrl (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic [aiec_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic start_event_in,
  input wire logic flush_event_in,
  input wire aiec_pkg::aiec_conv_ev_t conv_ev,
  input wire logic [15:0] conv_result,
  output logic conv_start,
  output logic conv_flush,
  output logic result_event_out,
  output logic window_event_out,
  output logic [aiec_pkg::NUM_PINS-1:0] pos_pin_sel,
  output aiec_pkg::aiec_int_src_t pos_int_sel,
  output logic pos_reserved,
  output logic irq
);
  import aiec_pkg::*;

  // --------------------------------------
  // state
  // --------------------------------------
  logic [7:0] event_control_q;
  logic [3:0] irq_enable_q;
  logic [3:0] irq_enable_d;
  logic [3:0] irq_flag_q;
  logic [3:0] irq_flag_d;
  logic [4:0] pos_sel_q;
  logic [15:0] result_q;
  logic result_unread_q;
  logic wprot_q;
  // synchroniser stages for the two event pins
  logic start_ev_s1_q;
  logic start_ev_s2_q;
  logic start_ev_s3_q;
  logic flush_ev_s1_q;
  logic flush_ev_s2_q;
  logic flush_ev_s3_q;

  // --------------------------------------
  // address decode
  // --------------------------------------
  // byte address compare, trimmed to the bus width
  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [7:0] ofs);
    hit = (a == ofs[ADDR_W-1:0]);
  endfunction

  // protected registers drop the whole write, no partial update
  wire wr_input = reg_wr && hit(reg_addr, OFS_INPUT_CTRL);
  wire wr_evctl = reg_wr && hit(reg_addr, OFS_EVENT_CONTROL) && !wprot_q;
  wire wr_ien_clr = reg_wr && hit(reg_addr, OFS_IRQ_ENABLE_CLEAR) && !wprot_q;
  wire wr_ien_set = reg_wr && hit(reg_addr, OFS_IRQ_ENABLE_SET) && !wprot_q;
  wire wr_flag = reg_wr && hit(reg_addr, OFS_IRQ_FLAG);
  wire wr_wprot = reg_wr && hit(reg_addr, OFS_WPROT);
  // either result byte counts as reading the result
  wire rd_res_lo = reg_rd && hit(reg_addr, OFS_RESULT);
  wire rd_res_hi = reg_rd && hit(reg_addr, OFS_RESULT + 8'h01);
  wire rd_result = rd_res_lo || rd_res_hi;

  // --------------------------------------
  // event inputs: synchronise and edge detect
  // --------------------------------------
  // two stages settle the pin, the third holds the last level for edges
  wire start_ev_edge = start_ev_s2_q && !start_ev_s3_q;
  wire flush_ev_edge = flush_ev_s2_q && !flush_ev_s3_q;

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      start_ev_s1_q <= 1'b0;
      start_ev_s2_q <= 1'b0;
      start_ev_s3_q <= 1'b0;
      flush_ev_s1_q <= 1'b0;
      flush_ev_s2_q <= 1'b0;
      flush_ev_s3_q <= 1'b0;
    end else begin
      start_ev_s1_q <= start_event_in;
      start_ev_s2_q <= start_ev_s1_q;
      start_ev_s3_q <= start_ev_s2_q;
      flush_ev_s1_q <= flush_event_in;
      flush_ev_s2_q <= flush_ev_s1_q;
      flush_ev_s3_q <= flush_ev_s2_q;
    end
  end

  // --------------------------------------
  // conversion requests and output events
  // --------------------------------------
  // a flush also starts a conversion, start and flush pulses in the same cycle
  wire flush_go = flush_ev_edge && event_control_q[EV_FLUSH_IN_BIT];
  wire start_go = (start_ev_edge && event_control_q[EV_START_IN_BIT]) || flush_go;

  // registered pulses toward the pipeline and the event system
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      conv_start <= 1'b0;
      conv_flush <= 1'b0;
      result_event_out <= 1'b0;
      window_event_out <= 1'b0;
    end else begin
      conv_start <= start_go;
      conv_flush <= flush_go;
      result_event_out <= conv_ev.result_store && event_control_q[EV_RESULT_OUT_BIT];
      window_event_out <= conv_ev.window_match && event_control_q[EV_WINDOW_OUT_BIT];
    end
  end

  // --------------------------------------
  // configuration registers
  // --------------------------------------
  // bits of event_control that hold state; the rest read back zero
  logic [7:0] ev_keep;
  always_comb begin
    ev_keep = 8'h00;
    ev_keep[EV_WINDOW_OUT_BIT] = 1'b1;
    ev_keep[EV_RESULT_OUT_BIT] = 1'b1;
    ev_keep[EV_FLUSH_IN_BIT] = 1'b1;
    ev_keep[EV_START_IN_BIT] = 1'b1;
  end

  // event control, input select and write protect
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      event_control_q <= RST_EVENT_CONTROL;
      pos_sel_q <= RST_POS_SEL;
      wprot_q <= 1'b0;
    end else begin
      if (wr_evctl) begin
        event_control_q <= reg_wdata & ev_keep; // only defined bits held
      end
      if (wr_input) begin
        pos_sel_q <= reg_wdata[4:0];
      end
      if (wr_wprot) begin
        wprot_q <= reg_wdata[0];
      end
    end
  end

  // next enables: set and clear views of one register
  always_comb begin
    irq_enable_d = irq_enable_q;
    if (wr_ien_clr) begin
      irq_enable_d = irq_enable_q & ~reg_wdata[3:0];
    end else if (wr_ien_set) begin
      irq_enable_d = irq_enable_q | reg_wdata[3:0];
    end
  end

  // interrupt enable register
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      irq_enable_q <= RST_IRQ_ENABLE;
    end else begin
      irq_enable_q <= irq_enable_d;
    end
  end

  // --------------------------------------
  // result store and flags
  // --------------------------------------
  // a read in the same cycle as a store takes the old value in time
  wire overrun_ev = conv_ev.result_store && result_unread_q && !rd_result;

  always_comb begin
    irq_flag_d = irq_flag_q;
    if (wr_flag) begin
      irq_flag_d = irq_flag_d & ~reg_wdata[3:0];
    end
    if (rd_result) begin
      irq_flag_d[IRQ_RESULT_AVAILABLE_BIT] = 1'b0;
      irq_flag_d[IRQ_WINDOW_MATCH_BIT] = 1'b0;
    end
    // set wins over clear
    if (conv_ev.sync_done) begin
      irq_flag_d[IRQ_SYNC_DONE_BIT] = 1'b1;
    end
    if (conv_ev.window_match) begin
      irq_flag_d[IRQ_WINDOW_MATCH_BIT] = 1'b1;
    end
    if (overrun_ev) begin
      irq_flag_d[IRQ_OVERRUN_BIT] = 1'b1;
    end
    if (conv_ev.result_store) begin
      irq_flag_d[IRQ_RESULT_AVAILABLE_BIT] = 1'b1;
    end
  end

  // flags, held result and whether software has read it
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      irq_flag_q <= 4'h0;
      result_q <= RST_RESULT;
      result_unread_q <= 1'b0;
    end else begin
      irq_flag_q <= irq_flag_d;
      if (conv_ev.result_store) begin
        result_q <= conv_result;
        result_unread_q <= 1'b1;
      end else if (rd_result) begin
        result_unread_q <= 1'b0;
      end
    end
  end

  // --------------------------------------
  // interrupt output
  // --------------------------------------
  // next flags against next enables, so a clear withdraws at once
  logic [3:0] irq_pend;
  assign irq_pend = irq_flag_d & irq_enable_d;

  // level output, registered
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      irq <= 1'b0;
    end else begin
      irq <= |irq_pend;
    end
  end

  // --------------------------------------
  // read data, one cycle after strobe
  // --------------------------------------
  // register picked by address; result bytes only on a read
  logic [7:0] rd_mux;
  always_comb begin
    rd_mux = 8'h00;
    if (hit(reg_addr, OFS_INPUT_CTRL)) begin
      rd_mux = {3'h0, pos_sel_q};
    end else if (hit(reg_addr, OFS_EVENT_CONTROL)) begin
      rd_mux = event_control_q;
    end else if (hit(reg_addr, OFS_IRQ_ENABLE_CLEAR) || hit(reg_addr, OFS_IRQ_ENABLE_SET)) begin
      rd_mux = {4'h0, irq_enable_q};
    end else if (hit(reg_addr, OFS_IRQ_FLAG)) begin
      rd_mux = {4'h0, irq_flag_q};
    end else if (rd_res_lo) begin
      rd_mux = result_q[7:0];
    end else if (rd_res_hi) begin
      rd_mux = result_q[15:8];
    end else if (hit(reg_addr, OFS_WPROT)) begin
      rd_mux = {7'h00, wprot_q};
    end
  end

  // idle cycles show zero so no stale byte lingers
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      reg_rdata <= 8'h00;
    end else begin
      reg_rdata <= reg_rd ? rd_mux : 8'h00;
    end
  end

  // --------------------------------------
  // positive input selection
  // --------------------------------------
  logic [NUM_PINS-1:0] pin_sel_c;
  aiec_int_src_t int_sel_c;
  logic reserved_c;

  // decoder sees the held code; its outputs are registered below
  aiec_pos_mux_dec u_dec (
    .code(pos_sel_q),
    .pin_sel(pin_sel_c),
    .int_sel(int_sel_c),
    .reserved(reserved_c)
  );

  // registered select outputs; reserved codes drive nothing
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      pos_pin_sel <= '0;
      pos_int_sel <= '0;
      pos_reserved <= 1'b0;
    end else begin
      pos_pin_sel <= pin_sel_c;
      pos_int_sel <= int_sel_c;
      pos_reserved <= reserved_c;
    end
  end
endmodule // aiec_ctrl

// >>> design/aiec_pos_mux_dec.sv
`timescale 1ns/1ps
module aiec_pos_mux_dec (
  input wire logic [4:0] code,
  output logic [aiec_pkg::NUM_PINS-1:0] pin_sel,
  output aiec_pkg::aiec_int_src_t int_sel,
  output logic reserved
);
  import aiec_pkg::*;

  // --------------------------------------
  // decode
  // --------------------------------------
  logic is_pin;
  assign is_pin = (code <= POS_PIN_LAST);

  // one pin per code in the pin range
  always_comb begin
    pin_sel = '0;
    if (is_pin) begin
      pin_sel[code] = 1'b1;
    end
  end

  // internal sources
  assign int_sel.temp = (code == POS_TEMP);
  assign int_sel.bandgap = (code == POS_BANDGAP);
  assign int_sel.quarter_core_supply = (code == POS_QUARTER_CORE);
  assign int_sel.quarter_io_supply = (code == POS_QUARTER_IO);
  assign int_sel.dac = (code == POS_DAC);
  assign reserved = !is_pin && (int_sel == '0);
endmodule // aiec_pos_mux_dec

// >>> inc/aiec_pkg.sv
package aiec_pkg;

  // ----------------------------------------
  // register offsets (byte addresses)
  // ----------------------------------------
  localparam int ADDR_W = 8;
  localparam logic [7:0] OFS_INPUT_CTRL = 8'h10;
  localparam logic [7:0] OFS_EVENT_CONTROL = 8'h14;
  localparam logic [7:0] OFS_IRQ_ENABLE_CLEAR = 8'h16;
  localparam logic [7:0] OFS_IRQ_ENABLE_SET = 8'h17;
  localparam logic [7:0] OFS_IRQ_FLAG = 8'h18;
  localparam logic [7:0] OFS_RESULT = 8'h1A;
  localparam logic [7:0] OFS_WPROT = 8'h1E;

  // ----------------------------------------
  // reset values
  // ----------------------------------------
  localparam logic [7:0] RST_EVENT_CONTROL = 8'h00;
  localparam logic [3:0] RST_IRQ_ENABLE = 4'h0;
  localparam logic [4:0] RST_POS_SEL = 5'h00;
  localparam logic [15:0] RST_RESULT = 16'h0000;

  // ----------------------------------------
  // field positions
  // ----------------------------------------
  localparam int EV_WINDOW_OUT_BIT = 5;
  localparam int EV_RESULT_OUT_BIT = 4;
  localparam int EV_FLUSH_IN_BIT = 1;
  localparam int EV_START_IN_BIT = 0;
  localparam int IRQ_SYNC_DONE_BIT = 3;
  localparam int IRQ_WINDOW_MATCH_BIT = 2;
  localparam int IRQ_OVERRUN_BIT = 1;
  localparam int IRQ_RESULT_AVAILABLE_BIT = 0;
  localparam int NUM_IRQ = 4;
  localparam int NUM_PINS = 20;

  // ----------------------------------------
  // positive input select codes
  // ----------------------------------------
  localparam logic [4:0] POS_PIN_LAST = 5'h13;
  localparam logic [4:0] POS_TEMP = 5'h18;
  localparam logic [4:0] POS_BANDGAP = 5'h19;
  localparam logic [4:0] POS_QUARTER_CORE = 5'h1A;
  localparam logic [4:0] POS_QUARTER_IO = 5'h1B;
  localparam logic [4:0] POS_DAC = 5'h1C;

  // internal source one-hot select
  typedef struct packed {
    logic dac;
    logic quarter_io_supply;
    logic quarter_core_supply;
    logic bandgap;
    logic temp;
  } aiec_int_src_t;

  // flags raised by the conversion pipeline
  typedef struct packed {
    logic sync_done;
    logic window_match;
    logic result_store;
  } aiec_conv_ev_t;

endpackage

// >>> tb/aiec_ctrl_sva.sv
`timescale 1ns/1ps
module aiec_ctrl_sva (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic start_event_in,
  input wire logic flush_event_in,
  input wire aiec_pkg::aiec_conv_ev_t conv_ev,
  input wire logic conv_start,
  input wire logic conv_flush,
  input wire logic result_event_out,
  input wire logic window_event_out,
  input wire logic [aiec_pkg::NUM_PINS-1:0] pos_pin_sel,
  input wire aiec_pkg::aiec_int_src_t pos_int_sel,
  input wire logic pos_reserved,
  input wire logic irq
);
  import aiec_pkg::*;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);
  // a flush event drives both pulses together
  sequence s_flush_pair;
    conv_start && conv_flush;
  endsequence
  a_flush_also_starts: assert property (conv_flush |-> s_flush_pair)
    else $error("flush pulse without start pulse");
  a_flush_has_cause: assert property (conv_flush |-> $past(flush_event_in, 3))
    else $error("flush pulse without flush event");
  a_start_has_cause: assert property (conv_start |->
    $past(start_event_in, 3) || $past(flush_event_in, 3))
    else $error("start pulse without event");
  a_result_ev_cause: assert property (result_event_out |-> $past(conv_ev.result_store))
    else $error("result event without result");
  a_window_ev_cause: assert property (window_event_out |-> $past(conv_ev.window_match))
    else $error("window event without match");
  a_select_one_hot: assert property (
    $onehot0({pos_pin_sel, pos_int_sel, pos_reserved}))
    else $error("positive select not one-hot");
  a_irq_rise_cause: assert property ($rose(irq) |->
    $past(conv_ev != 3'h0) || $past(reg_wr))
    else $error("irq rose without cause");
  a_irq_fall_cause: assert property ($fell(irq) |-> $past(reg_wr) || $past(reg_rd))
    else $error("irq fell without access");
endmodule // aiec_ctrl_sva

bind aiec_ctrl aiec_ctrl_sva sva (.clk_sys(clk_sys), .reset(reset), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .start_event_in(start_event_in), .flush_event_in(flush_event_in),
  .conv_ev(conv_ev), .conv_start(conv_start), .conv_flush(conv_flush),
  .result_event_out(result_event_out), .window_event_out(window_event_out),
  .pos_pin_sel(pos_pin_sel), .pos_int_sel(pos_int_sel), .pos_reserved(pos_reserved), .irq(irq));

// >>> tb/aiec_far_side.sv
`timescale 1ns/1ps
module aiec_far_side (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic conv_start,
  input wire logic sync_req,
  output aiec_pkg::aiec_conv_ev_t conv_ev,
  output logic [15:0] conv_result
);
  import aiec_pkg::*;
  logic [3:0] pipe_q;
  logic [15:0] val_q;
  // pipeline stand-in: result four cycles after start, value steps each time
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      pipe_q <= 4'h0;
      val_q <= 16'h0A5C;
    end else begin
      pipe_q <= {pipe_q[2:0], conv_start};
      if (pipe_q[3]) val_q <= val_q + 16'h0111;
    end
  end
  // odd results match the window; bus shows garbage outside a store
  assign conv_ev = '{sync_done: sync_req, window_match: pipe_q[3] & val_q[0],
    result_store: pipe_q[3]};
  assign conv_result = pipe_q[3] ? val_q : ~val_q;
endmodule // aiec_far_side

// >>> tb/testbench.sv
`timescale 1ns/1ps
module testbench;
  import aiec_pkg::*;
  logic clk_sys, reset, reg_wr, reg_rd, start_event_in, flush_event_in, sync_req;
  logic [7:0] reg_addr, reg_wdata, reg_rdata;
  logic conv_start, conv_flush, result_event_out, window_event_out, pos_reserved, irq;
  logic [NUM_PINS-1:0] pos_pin_sel;
  aiec_int_src_t pos_int_sel;
  aiec_conv_ev_t conv_ev;
  logic [15:0] conv_result;
  int bad_count, checks_done, cyc, n_st, n_fl, n_re, n_we, ev, en, fl, rv, lastv, unread, nw;
  int i, k, sa, sb;
  aiec_ctrl uut (.clk_sys(clk_sys), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .start_event_in(start_event_in),
    .flush_event_in(flush_event_in), .conv_ev(conv_ev), .conv_result(conv_result),
    .conv_start(conv_start), .conv_flush(conv_flush), .result_event_out(result_event_out),
    .window_event_out(window_event_out), .pos_pin_sel(pos_pin_sel), .pos_int_sel(pos_int_sel),
    .pos_reserved(pos_reserved), .irq(irq));
  aiec_far_side far (.clk_sys(clk_sys), .reset(reset), .conv_start(conv_start),
    .sync_req(sync_req), .conv_ev(conv_ev), .conv_result(conv_result));
  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end
  // pulse counters and hang guard
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    n_st <= n_st + (conv_start === 1'b1);
    n_fl <= n_fl + (conv_flush === 1'b1);
    n_re <= n_re + (result_event_out === 1'b1);
    n_we <= n_we + (window_event_out === 1'b1);
    if (cyc > 5000) begin
      bad_count++;
      results();
    end
  end
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      $display("Error %s expected %0h seen %0h", nm, exp, got);
      bad_count++;
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
    @(posedge clk_sys);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string nm);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 chk(nm, exp, reg_rdata);
    @(posedge clk_sys);
  endtask
  task automatic settle;
    repeat (2) @(posedge clk_sys);
    #1;
  endtask
  // event pin held three cycles, then time for the conversion to land
  task automatic pin(input int f);
    if (f) flush_event_in <= 1'b1;
    else start_event_in <= 1'b1;
    repeat (3) @(posedge clk_sys);
    flush_event_in <= 1'b0;
    start_event_in <= 1'b0;
    repeat (12) @(posedge clk_sys);
  endtask
  // reference of one stored result
  task automatic conv;
    if (unread) fl |= 2;
    unread = 1;
    fl |= 1;
    if (rv & 1) begin
      fl |= 4;
      nw++;
    end
    lastv = rv;
    rv += 'h111;
  endtask
  task automatic results;
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  initial begin
    {reset, reg_wr, reg_rd, start_event_in, flush_event_in, sync_req} = 6'h20;
    {reg_addr, reg_wdata} = 16'h0000;
    {bad_count, checks_done, cyc, n_st, n_fl, n_re, n_we, fl, en, unread, nw} = 0;
    rv = 'h0A5C;
    k = $urandom(62056);
    repeat (5) @(posedge clk_sys);
    reset <= 1'b0;
    @(posedge clk_sys);
    // reset values, unmapped place, protection
    rd(OFS_EVENT_CONTROL, 8'h00, "event_control");
    rd(OFS_IRQ_ENABLE_SET, 8'h00, "irq_enable_set");
    wr(8'h30, 8'hFF);
    rd(8'h30, 8'h00, "unmapped");
    ev = $urandom & 'hFF;
    wr(OFS_EVENT_CONTROL, ev);
    rd(OFS_EVENT_CONTROL, ev & 'h33, "event_control");
    wr(OFS_WPROT, 8'h01);
    wr(OFS_EVENT_CONTROL, ~ev);
    wr(OFS_IRQ_ENABLE_SET, 8'h0F);
    rd(OFS_EVENT_CONTROL, ev & 'h33, "protected ctrl");
    rd(OFS_IRQ_ENABLE_CLEAR, 8'h00, "protected enable");
    wr(OFS_WPROT, 8'h00);
    $display("test registers done");
    // enable set and clear
    en = $urandom & 'hF;
    wr(OFS_IRQ_ENABLE_SET, en);
    wr(OFS_IRQ_ENABLE_SET, 8'h00);
    rd(OFS_IRQ_ENABLE_CLEAR, en, "enable after set");
    wr(OFS_IRQ_ENABLE_CLEAR, 8'h05);
    en &= 'hA;
    wr(OFS_IRQ_ENABLE_CLEAR, 8'h00);
    rd(OFS_IRQ_ENABLE_SET, en, "enable after clear");
    $display("test enables done");
    // every code; reserved ones only to see them flagged, no sampling time here
    for (i = 0; i < 32; i++) begin
      wr(OFS_INPUT_CTRL, i);
      settle();
      chk("pos_pin_sel", (i <= 19) ? (1 << i) : 0, pos_pin_sel);
      chk("pos_int_sel", (i >= 24 && i <= 28) ? (1 << (i - 24)) : 0, pos_int_sel);
      chk("pos_reserved", (i > 19 && !(i >= 24 && i <= 28)), pos_reserved);
      @(posedge clk_sys);
    end
    $display("test select done");
    // event inputs under each enable pair
    for (k = 0; k < 4; k++) begin
      wr(OFS_EVENT_CONTROL, k);
      sa = n_st;
      pin(0);
      chk("start count", k & 1, n_st - sa);
      if (k & 1) conv();
      sa = n_st;
      sb = n_fl;
      pin(1);
      chk("flush start count", k >> 1, n_st - sa);
      chk("flush count", k >> 1, n_fl - sb);
      if (k & 2) conv();
    end
    $display("test event inputs done");
    // results, overrun, flags and interrupt
    wr(OFS_IRQ_FLAG, 8'h0F);
    rd(OFS_RESULT, lastv & 'hFF, "result low");
    {fl, unread, nw} = 0;
    wr(OFS_EVENT_CONTROL, 8'h31);
    wr(OFS_IRQ_ENABLE_SET, 8'h0F);
    sa = n_re;
    sb = n_we;
    pin(0);
    conv();
    pin(0);
    conv();
    sync_req <= 1'b1;
    @(posedge clk_sys);
    sync_req <= 1'b0;
    fl |= 8;
    settle();
    chk("result events", 2, n_re - sa);
    chk("window events", nw, n_we - sb);
    chk("irq", 1, irq);
    @(posedge clk_sys);
    rd(OFS_IRQ_FLAG, fl, "flags");
    rd(OFS_RESULT + 8'h01, lastv >> 8, "result high");
    fl &= 'hA;
    rd(OFS_IRQ_FLAG, fl, "flags after read");
    for (i = 0; i < 4; i++) begin
      wr(OFS_IRQ_ENABLE_CLEAR, 8'h0F);
      wr(OFS_IRQ_ENABLE_SET, 1 << i);
      settle();
      chk("irq per source", (fl >> i) & 1, irq);
      @(posedge clk_sys);
    end
    wr(OFS_IRQ_ENABLE_SET, 8'h0F);
    wr(OFS_IRQ_FLAG, 8'h0F);
    settle();
    chk("irq after flag clear", 0, irq);
    @(posedge clk_sys);
    wr(OFS_EVENT_CONTROL, 8'h01);
    sa = n_re;
    pin(0);
    chk("result events off", 0, n_re - sa);
    $display("test conversion events done");
    results();
  end
endmodule // testbench
